/* include/epo_defines.vh */
// register map, field positions, reset values and mode codes of the pwm output stage
// definitions only; included by every design file of the block
`ifndef EPO_DEFINES_VH
`define EPO_DEFINES_VH

// byte offsets on the register bus
`define EPO_OFS_CONTROL    8'h00
`define EPO_OFS_DUTY_HIGH  8'h04
`define EPO_OFS_PERIOD     8'h08
`define EPO_OFS_DEADBAND   8'h0C
`define EPO_OFS_STATUS     8'h10

// control register fields
`define EPO_CFG_HI         7
`define EPO_CFG_LO         6
`define EPO_DUTY_LO_HI     5
`define EPO_DUTY_LO_LO     4
`define EPO_MODE_HI        3
`define EPO_MODE_LO        0
`define EPO_POL_AC_BIT     1
`define EPO_POL_BD_BIT     0

// reset values
`define EPO_RST_CONTROL    8'h00
`define EPO_RST_DUTY_HIGH  8'h00
`define EPO_RST_PERIOD     8'hFF
`define EPO_RST_DEADBAND   7'h00

// mode and output configuration codes
`define EPO_MODE_OFF       4'h0
`define EPO_MODE_PWM_TOP   2'h3
`define EPO_CFG_SINGLE     2'h0
`define EPO_CFG_FWD        2'h1
`define EPO_CFG_HALF       2'h2
`define EPO_CFG_REV        2'h3

// bus answers
`define EPO_RESP_OKAY      2'h0
`define EPO_RESP_SLVERR    2'h2

`endif

/* rtl/epo_pwm_core.v */
// period timer and ten-bit duty comparator producing the raw modulated waveform
// assumes the caller holds enable low whenever pwm operation is not selected
`timescale 1ns/1ps
`include "epo_defines.vh"

module epo_pwm_core #(
    parameter PERIOD_W = 8
) (
    // clock and reset
    input  wire                  clk,
    input  wire                  resetn,
    // control
    input  wire                  enable,
    input  wire [PERIOD_W-1:0]   period,
    input  wire [PERIOD_W+1:0]   duty,
    // waveform
    output reg                   raw,
    output reg                   period_start
);

    reg  [PERIOD_W+1:0] count;
    reg  [PERIOD_W+1:0] duty_live;
    wire                last = (count[PERIOD_W+1:2] == period) && (count[1:0] == 2'h3);

    // duty is buffered at the period boundary so a write never cuts a pulse short
    always @(posedge clk) begin
        if (!resetn || !enable) begin
            count        <= {(PERIOD_W+2){1'b0}};
            duty_live    <= {(PERIOD_W+2){1'b0}};
            raw          <= 1'b0;
            period_start <= 1'b0;
        end else begin
            period_start <= last;
            if (last) begin
                count     <= {(PERIOD_W+2){1'b0}};
                duty_live <= duty;
                raw       <= (duty != {(PERIOD_W+2){1'b0}});
            end else begin
                count <= count + {{(PERIOD_W+1){1'b0}}, 1'b1};
                raw   <= ((count + {{(PERIOD_W+1){1'b0}}, 1'b1}) < duty_live);
            end
        end
    end

endmodule

/* rtl/epo_deadband.v */
// splits the raw waveform into a complementary pair with a dead gap on each edge
// assumes the raw input is registered in the same clock domain
`timescale 1ns/1ps
`include "epo_defines.vh"

module epo_deadband #(
    parameter DEAD_W = 7
) (
    // clock and reset
    input  wire              clk,
    input  wire              resetn,
    // control
    input  wire              enable,
    input  wire [DEAD_W-1:0] dead,
    // waveform
    input  wire              raw,
    output reg               mod_a,
    output reg               mod_b
);

    reg              raw_seen;
    reg [DEAD_W-1:0] gap;

    // both halves stay off while the gap runs, then the new side turns on
    always @(posedge clk) begin
        if (!resetn || !enable) begin
            raw_seen <= 1'b0;
            gap      <= {DEAD_W{1'b0}};
            mod_a    <= 1'b0;
            mod_b    <= 1'b0;
        end else if (raw != raw_seen) begin
            raw_seen <= raw;
            mod_a    <= 1'b0;
            mod_b    <= 1'b0;
            gap      <= dead;
        end else if (gap != {DEAD_W{1'b0}}) begin
            gap <= gap - {{(DEAD_W-1){1'b0}}, 1'b1};
        end else begin
            mod_a <= raw_seen;
            mod_b <= ~raw_seen;
        end
    end

endmodule

/* rtl/epo_top.v */
// pwm output configuration stage with an axi4-lite register slave
// assumes compare logic outside supplies the pin-a level in compare mode;
// bus and pins are synchronous to clk
//
// Functional notes
// (RL1) output config ignored outside pwm operation
// (RL2) non-pwm: pin a capture/compare, b-d ports
// (RL3) pwm single: only pin a modulated
// (RL4) forward: d modulated, a active, b/c inactive
// (RL5) half bridge: a/b complementary with dead-band
// (RL6) reverse: b modulated, c active, a/d inactive
// (RL7) duty is ten bits: high register plus two
// (RL8) mode zero turns unit off and resets
// (RL9) low mode bits set a/c, b/d polarity
`timescale 1ns/1ps
`include "epo_defines.vh"

module epo_top #(
    parameter ADDR_W   = 8,
    parameter PERIOD_W = 8,
    parameter DEAD_W   = 7
) (
    // clock and reset
    input  wire              clk,
    input  wire              resetn,
    // axi4-lite write address
    input  wire [ADDR_W-1:0] s_axi_awaddr,
    input  wire [2:0]        s_axi_awprot,
    input  wire              s_axi_awvalid,
    output wire              s_axi_awready,
    // axi4-lite write data
    input  wire [31:0]       s_axi_wdata,
    input  wire [3:0]        s_axi_wstrb,
    input  wire              s_axi_wvalid,
    output wire              s_axi_wready,
    // axi4-lite write response
    output reg  [1:0]        s_axi_bresp,
    output reg               s_axi_bvalid,
    input  wire              s_axi_bready,
    // axi4-lite read address
    input  wire [ADDR_W-1:0] s_axi_araddr,
    input  wire [2:0]        s_axi_arprot,
    input  wire              s_axi_arvalid,
    output wire              s_axi_arready,
    // axi4-lite read data
    output reg  [31:0]       s_axi_rdata,
    output reg  [1:0]        s_axi_rresp,
    output reg               s_axi_rvalid,
    input  wire              s_axi_rready,
    // capture/compare side
    input  wire              compare_level,
    input  wire              compare_drive,
    output reg               capture_in,
    output reg               period_start,
    // output pins, enable low while driven
    input  wire              pwm_pin_a_in,
    output reg               pwm_pin_a_out,
    output reg               pwm_pin_a_oe_n,
    output reg               pwm_pin_b_out,
    output reg               pwm_pin_b_oe_n,
    output reg               pwm_pin_c_out,
    output reg               pwm_pin_c_oe_n,
    output reg               pwm_pin_d_out,
    output reg               pwm_pin_d_oe_n
);

    // register file
    reg [7:0]          capture_pwm_control;
    reg [PERIOD_W-1:0] duty_high_register;
    reg [PERIOD_W-1:0] period;
    reg [DEAD_W-1:0]   deadband;

    // control fields
    wire [1:0] output_config = capture_pwm_control[`EPO_CFG_HI:`EPO_CFG_LO];
    wire [1:0] duty_low_bits = capture_pwm_control[`EPO_DUTY_LO_HI:`EPO_DUTY_LO_LO];
    wire [3:0] mode_select   = capture_pwm_control[`EPO_MODE_HI:`EPO_MODE_LO];
    wire       unit_off      = (mode_select == `EPO_MODE_OFF);
    wire       pwm_mode      = (mode_select[3:2] == `EPO_MODE_PWM_TOP);
    wire       pol_ac_low    = mode_select[`EPO_POL_AC_BIT];
    wire       pol_bd_low    = mode_select[`EPO_POL_BD_BIT];

    // ten-bit duty built from the high register and the two low bits
    wire [PERIOD_W+1:0] duty_value = {duty_high_register, duty_low_bits}; // see (RL7)

    // waveform sources
    wire raw;
    wire raw_start;
    wire mod_a;
    wire mod_b;

    // timer and comparator are held cleared unless pwm is selected
    epo_pwm_core #(
        .PERIOD_W (PERIOD_W)
    ) u_core (
        .clk          (clk),
        .resetn       (resetn),
        .enable       (pwm_mode),
        .period       (period),
        .duty         (duty_value),
        .raw          (raw),
        .period_start (raw_start)
    );

    // complementary pair only matters in half-bridge, but runs in any pwm mode
    epo_deadband #(
        .DEAD_W (DEAD_W)
    ) u_dead (
        .clk    (clk),
        .resetn (resetn),
        .enable (pwm_mode),
        .dead   (deadband),
        .raw    (raw),
        .mod_a  (mod_a),
        .mod_b  (mod_b)
    );

    // axi write channel state
    reg              aw_held;
    reg              w_held;
    reg [ADDR_W-1:0] aw_addr;
    reg [31:0]       w_data;
    reg [3:0]        w_strb;

    assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
    assign s_axi_arready = ~s_axi_rvalid;

    wire do_write = aw_held & w_held & ~s_axi_bvalid;
    wire wr_hit   = (aw_addr == `EPO_OFS_CONTROL) || (aw_addr == `EPO_OFS_DUTY_HIGH) ||
                    (aw_addr == `EPO_OFS_PERIOD) || (aw_addr == `EPO_OFS_DEADBAND);

    // address and data are caught in either order; the write happens once both are in
    always @(posedge clk) begin
        if (!resetn) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            aw_addr      <= {ADDR_W{1'b0}};
            w_data       <= 32'h0000_0000;
            w_strb       <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `EPO_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? `EPO_RESP_OKAY : `EPO_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // register writes; only byte lane 0 carries register bits
    always @(posedge clk) begin
        if (!resetn) begin
            capture_pwm_control <= `EPO_RST_CONTROL;
            duty_high_register  <= `EPO_RST_DUTY_HIGH;
            period              <= `EPO_RST_PERIOD;
            deadband            <= `EPO_RST_DEADBAND;
        end else if (do_write && w_strb[0]) begin
            if (aw_addr == `EPO_OFS_CONTROL) begin
                capture_pwm_control <= w_data[7:0];
            end else if (aw_addr == `EPO_OFS_DUTY_HIGH) begin
                duty_high_register <= w_data[PERIOD_W-1:0];
            end else if (aw_addr == `EPO_OFS_PERIOD) begin
                period <= w_data[PERIOD_W-1:0];
            end else if (aw_addr == `EPO_OFS_DEADBAND) begin
                deadband <= w_data[DEAD_W-1:0];
            end
        end
    end

    // read decode; status shows the live pin drive
    reg [31:0] rd_word;
    reg        rd_hit;

    always @* begin
        rd_word = 32'h0000_0000;
        rd_hit  = 1'b1;
        if (s_axi_araddr == `EPO_OFS_CONTROL) begin
            rd_word[7:0] = capture_pwm_control;
        end else if (s_axi_araddr == `EPO_OFS_DUTY_HIGH) begin
            rd_word[PERIOD_W-1:0] = duty_high_register;
        end else if (s_axi_araddr == `EPO_OFS_PERIOD) begin
            rd_word[PERIOD_W-1:0] = period;
        end else if (s_axi_araddr == `EPO_OFS_DEADBAND) begin
            rd_word[DEAD_W-1:0] = deadband;
        end else if (s_axi_araddr == `EPO_OFS_STATUS) begin
            rd_word[3:0] = {pwm_pin_d_out, pwm_pin_c_out, pwm_pin_b_out, pwm_pin_a_out};
            rd_word[7:4] = {pwm_pin_d_oe_n, pwm_pin_c_oe_n, pwm_pin_b_oe_n, pwm_pin_a_oe_n};
            rd_word[8]   = raw;
            rd_word[9]   = pwm_mode;
        end else begin
            rd_hit = 1'b0;
        end
    end

    // read answer registered on the same edge that takes the address
    always @(posedge clk) begin
        if (!resetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `EPO_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= rd_hit ? `EPO_RESP_OKAY : `EPO_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // pin routing; active level of a pin is 1 unless its pair is set active-low
    reg next_a_out;
    reg next_a_oe_n;
    reg next_b_out;
    reg next_b_oe_n;
    reg next_c_out;
    reg next_c_oe_n;
    reg next_d_out;
    reg next_d_oe_n;

    always @* begin
        next_a_out  = 1'b0;
        next_a_oe_n = 1'b1;
        next_b_out  = 1'b0;
        next_b_oe_n = 1'b1;
        next_c_out  = 1'b0;
        next_c_oe_n = 1'b1;
        next_d_out  = 1'b0;
        next_d_oe_n = 1'b1;
        if (unit_off) begin
            // everything released, as after reset
            next_a_oe_n = 1'b1; // see (RL8)
        end else if (!pwm_mode) begin
            // compare logic owns pin a; output config not looked at
            next_a_out  = compare_level; // see (RL1) see (RL2)
            next_a_oe_n = ~compare_drive;
        end else begin
            case (output_config)
                `EPO_CFG_SINGLE: begin
                    next_a_out  = raw ^ pol_ac_low; // see (RL3) see (RL9)
                    next_a_oe_n = 1'b0;
                end
                `EPO_CFG_FWD: begin
                    next_d_out  = raw ^ pol_bd_low; // see (RL4) see (RL9)
                    next_a_out  = ~pol_ac_low;
                    next_b_out  = pol_bd_low;
                    next_c_out  = pol_ac_low;
                    next_a_oe_n = 1'b0;
                    next_b_oe_n = 1'b0;
                    next_c_oe_n = 1'b0;
                    next_d_oe_n = 1'b0;
                end
                `EPO_CFG_HALF: begin
                    next_a_out  = mod_a ^ pol_ac_low; // see (RL5) see (RL9)
                    next_b_out  = mod_b ^ pol_bd_low;
                    next_a_oe_n = 1'b0;
                    next_b_oe_n = 1'b0;
                end
                default: begin
                    next_b_out  = raw ^ pol_bd_low; // see (RL6) see (RL9)
                    next_c_out  = ~pol_ac_low;
                    next_a_out  = pol_ac_low;
                    next_d_out  = pol_bd_low;
                    next_a_oe_n = 1'b0;
                    next_b_oe_n = 1'b0;
                    next_c_oe_n = 1'b0;
                    next_d_oe_n = 1'b0;
                end
            endcase
        end
    end

    // pins registered so no decode glitch reaches a power stage
    always @(posedge clk) begin
        if (!resetn) begin
            pwm_pin_a_out  <= 1'b0;
            pwm_pin_a_oe_n <= 1'b1;
            pwm_pin_b_out  <= 1'b0;
            pwm_pin_b_oe_n <= 1'b1;
            pwm_pin_c_out  <= 1'b0;
            pwm_pin_c_oe_n <= 1'b1;
            pwm_pin_d_out  <= 1'b0;
            pwm_pin_d_oe_n <= 1'b1;
            capture_in     <= 1'b0;
            period_start   <= 1'b0;
        end else begin
            pwm_pin_a_out  <= next_a_out;
            pwm_pin_a_oe_n <= next_a_oe_n;
            pwm_pin_b_out  <= next_b_out;
            pwm_pin_b_oe_n <= next_b_oe_n;
            pwm_pin_c_out  <= next_c_out;
            pwm_pin_c_oe_n <= next_c_oe_n;
            pwm_pin_d_out  <= next_d_out;
            pwm_pin_d_oe_n <= next_d_oe_n;
            // capture sees pin a only in capture/compare operation
            capture_in     <= pwm_pin_a_in & ~unit_off & ~pwm_mode; // see (RL2)
            period_start   <= raw_start;
        end
    end

endmodule

/* tb/epo_checker_assertions.sv */
// checker: bus handshake and pin routing relations of the pwm output stage
// assumes it is bound to epo_top and sees only its ports, one clock domain
`timescale 1ns/1ps
module epo_checker (
    // clock and reset
    input wire       clk,
    input wire       resetn,
    // register bus
    input wire       s_axi_awvalid,
    input wire       s_axi_awready,
    input wire       s_axi_wvalid,
    input wire       s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire       s_axi_bvalid,
    input wire       s_axi_bready,
    input wire       s_axi_arvalid,
    input wire       s_axi_arready,
    input wire       s_axi_rvalid,
    input wire       s_axi_rready,
    // waveform and pins
    input wire       period_start,
    input wire       pwm_pin_a_out,
    input wire       pwm_pin_c_out,
    input wire       pwm_pin_a_oe_n,
    input wire       pwm_pin_b_oe_n,
    input wire       pwm_pin_c_oe_n,
    input wire       pwm_pin_d_oe_n
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    // pins leave reset released, so no bridge half is driven blind
    a_reset_release: assert property ($rose(resetn) |->
        pwm_pin_a_oe_n && pwm_pin_b_oe_n && pwm_pin_c_oe_n && pwm_pin_d_oe_n)
        else $error("pins driven right after reset");
    // b or d only ever driven in a bridge mode, which also drives a
    a_bd_need_a: assert property ((!pwm_pin_b_oe_n || !pwm_pin_d_oe_n) |-> !pwm_pin_a_oe_n)
        else $error("pin b or d driven without pin a");
    // c driven means full bridge: all four driven, a and c opposite
    a_c_full_bridge: assert property (!pwm_pin_c_oe_n |->
        !pwm_pin_a_oe_n && !pwm_pin_b_oe_n && !pwm_pin_d_oe_n && (pwm_pin_a_out != pwm_pin_c_out))
        else $error("full bridge pin set inconsistent");
    // write answer held until taken
    a_bvalid_hold: assert property ($fell(s_axi_bvalid) |-> $past(s_axi_bready))
        else $error("write response dropped early");
    // read answer held until taken
    a_rvalid_hold: assert property ($fell(s_axi_rvalid) |-> $past(s_axi_rready))
        else $error("read response dropped early");
    // no new write while a response waits
    a_busy_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response pending");
    // no new read while read data waits
    a_read_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while data pending");
    // read answered one edge after the address is taken
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered in time");
    // write answered soon after address and data are taken together
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:2] s_axi_bvalid)
        else $error("write not answered in time");
    // period marker is a single-cycle pulse
    a_start_pulse: assert property (period_start |=> !period_start)
        else $error("period start longer than one cycle");
endmodule

bind epo_top epo_checker u_epo_checker (
    .clk(clk), .resetn(resetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .period_start(period_start), .pwm_pin_a_out(pwm_pin_a_out), .pwm_pin_c_out(pwm_pin_c_out),
    .pwm_pin_a_oe_n(pwm_pin_a_oe_n), .pwm_pin_b_oe_n(pwm_pin_b_oe_n),
    .pwm_pin_c_oe_n(pwm_pin_c_oe_n), .pwm_pin_d_oe_n(pwm_pin_d_oe_n)
);

/* tb/epo_top_tb.sv */
// self-checking bench: registers, pin routing, duty and dead band of the pwm output stage
// assumes epo_top with default parameters and a 250 MHz clock
`timescale 1ns/1ps
`include "epo_defines.vh"

module epo_top_tb;
    // signals named as the ports they drive or watch
    logic        clk           = 1'h0;
    logic        resetn        = 1'h0;
    logic [7:0]  s_axi_awaddr  = 8'h00;
    logic [7:0]  s_axi_araddr  = 8'h00;
    logic [2:0]  s_axi_awprot  = 3'h0;
    logic [2:0]  s_axi_arprot  = 3'h0;
    logic [31:0] s_axi_wdata   = 32'h0;
    logic [3:0]  s_axi_wstrb   = 4'hF;
    logic        s_axi_awvalid = 1'h0;
    logic        s_axi_wvalid  = 1'h0;
    logic        s_axi_bready  = 1'h0;
    logic        s_axi_arvalid = 1'h0;
    logic        s_axi_rready  = 1'h0;
    logic        compare_level = 1'h0;
    logic        compare_drive = 1'h0;
    logic        pwm_pin_a_in  = 1'h0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic        capture_in, period_start;
    logic        pwm_pin_a_out, pwm_pin_b_out, pwm_pin_c_out, pwm_pin_d_out;
    logic        pwm_pin_a_oe_n, pwm_pin_b_oe_n, pwm_pin_c_oe_n, pwm_pin_d_oe_n;
    int          miscompares   = 0;
    int          n_checks      = 0;

    // every port joined to the signal of the same name
    epo_top dut (.*);

    always #2 clk = ~clk;

    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            miscompares++;
            $display("CHECK FAILED %s exp %h seen %h", nm, e, s);
        end
    endtask

    task end_sim;
        if (miscompares == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // ready sampled at the edge; bready held high from the request until bvalid is seen
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid  <= 1'h1;
        s_axi_bready  <= 1'h1;
        forever begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid) begin
                r = s_axi_bresp;
                s_axi_bready <= 1'h0;
                break;
            end
        end
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready  <= 1'h1;
        forever begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid) begin
                d = s_axi_rdata;
                r = s_axi_rresp;
                s_axi_rready <= 1'h0;
                break;
            end
        end
    endtask

    // write control, then let 40 cycles, two and a half 16-cycle periods, pass so buffered duty lands
    task automatic ctl(input logic [7:0] v);
        logic [1:0] r;
        wr(`EPO_OFS_CONTROL, {24'h0, v}, r);
        repeat (40) @(posedge clk);
    endtask

    // levels compared only where the pin is expected driven
    task automatic chk_pins(input string nm, input logic [3:0] oe, input logic [3:0] lv);
        logic [3:0] so;
        logic [3:0] sl;
        so = {pwm_pin_a_oe_n, pwm_pin_b_oe_n, pwm_pin_c_oe_n, pwm_pin_d_oe_n};
        sl = {pwm_pin_a_out, pwm_pin_b_out, pwm_pin_c_out, pwm_pin_d_out} & ~oe;
        chk(nm, {so, sl}, {oe, lv & ~oe});
    endtask

    // cbd counts the modulated bridge leg, b or d; ps counts period marks
    task automatic count_hi(input int n, output int ca, output int gap, output int both,
                            output int cbd, output int ps);
        ca = 0;
        gap = 0;
        both = 0;
        cbd = 0;
        ps = 0;
        repeat (n) begin
            @(posedge clk);
            ca += pwm_pin_a_out;
            gap += !pwm_pin_a_out && !pwm_pin_b_out;
            both += pwm_pin_a_out && pwm_pin_b_out;
            cbd += pwm_pin_b_out || pwm_pin_d_out;
            ps += period_start;
        end
    endtask

    task automatic t_regs;
        logic [7:0]  ofs[4] = '{`EPO_OFS_CONTROL, `EPO_OFS_DUTY_HIGH, `EPO_OFS_PERIOD, `EPO_OFS_DEADBAND};
        logic [31:0] rv[4]  = '{`EPO_RST_CONTROL, `EPO_RST_DUTY_HIGH, `EPO_RST_PERIOD, `EPO_RST_DEADBAND};
        logic [31:0] d;
        logic [1:0]  r;
        for (int k = 0; k < 4; k++) begin
            rd(ofs[k], d, r);
            chk("reset value", d, rv[k]);
            chk("read resp", r, `EPO_RESP_OKAY);
        end
        rd(8'h14, d, r);
        chk("unmapped read data", d, 32'h0);
        chk("unmapped read resp", r, `EPO_RESP_SLVERR);
        wr(8'h14, 32'hFF, r);
        chk("unmapped write resp", r, `EPO_RESP_SLVERR);
        s_axi_wstrb <= 4'h0;
        wr(`EPO_OFS_CONTROL, 32'h5A, r);
        s_axi_wstrb <= 4'hF;
        rd(`EPO_OFS_CONTROL, d, r);
        chk("strobed-off write", d, 32'h0);
        wr(`EPO_OFS_CONTROL, 32'hFFFF_FF5A, r);
        rd(`EPO_OFS_CONTROL, d, r);
        chk("control read back", d, 32'h5A);
        wr(`EPO_OFS_CONTROL, 32'h0, r);
    endtask

    // compare mode under every output config: only pin a follows compare logic
    task automatic t_ports;
        compare_drive <= 1'h1;
        for (int c = 0; c < 4; c++) begin
            compare_level <= c[0];
            ctl({c[1:0], 6'h08});
            chk_pins("compare routing", 4'h7, {c[0], 3'h0});
        end
        compare_drive <= 1'h0;
        pwm_pin_a_in  <= 1'h1;
        ctl(8'hC4);
        chk_pins("capture released", 4'hF, 4'h0);
        chk("capture input", capture_in, 32'h1);
    endtask

    // raw held high by full duty; every config with every polarity pair
    task automatic t_route;
        logic [3:0] oe_t[4] = '{4'h7, 4'h0, 4'h3, 4'h0};
        logic [1:0] r;
        logic [3:0] lv;
        wr(`EPO_OFS_PERIOD, 32'h3, r);
        wr(`EPO_OFS_DUTY_HIGH, 32'hFF, r);
        for (int i = 0; i < 16; i++) begin
            ctl({i[3:2], 4'hF, i[1:0]});
            lv = {~i[1], i[0], i[1], ~i[0]} ^ {4{i[3:2] == 2'h3}};
            chk_pins("pwm routing", oe_t[i[3:2]], lv);
        end
        ctl(8'h00);
        chk_pins("unit off", 4'hF, 4'h0);
        chk("capture gated", capture_in, 32'h0);
    endtask

    task automatic t_duty;
        logic [1:0] r;
        int         ca;
        int         gap;
        int         both;
        int         cbd;
        int         ps;
        wr(`EPO_OFS_DUTY_HIGH, 32'h1, r);
        ctl(8'h2C);
        count_hi(16, ca, gap, both, cbd, ps);
        chk("duty six", ca, 6);
        chk("period marks", ps, 1);
        // full bridge legs carry the same six-cycle pulse
        ctl(8'h6C);
        count_hi(16, ca, gap, both, cbd, ps);
        chk("forward leg d", cbd, 6);
        ctl(8'hEC);
        count_hi(16, ca, gap, both, cbd, ps);
        chk("reverse leg b", cbd, 6);
        wr(`EPO_OFS_DUTY_HIGH, 32'h0, r);
        ctl(8'h3C);
        count_hi(16, ca, gap, both, cbd, ps);
        chk("duty three", ca, 3);
        // half duty, gap of three cycles at each raw edge
        wr(`EPO_OFS_DUTY_HIGH, 32'h2, r);
        wr(`EPO_OFS_DEADBAND, 32'h2, r);
        ctl(8'h8C);
        count_hi(32, ca, gap, both, cbd, ps);
        chk("half a on", ca, 10);
        chk("half gap", gap, 12);
        chk("half overlap", both, 0);
    endtask

    initial begin
        repeat (6) @(posedge clk);
        resetn <= 1'h1;
        t_regs;
        t_ports;
        t_route;
        t_duty;
        end_sim;
    end

    // whole run needs under 2000 cycles
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        end_sim;
    end
endmodule
